// ==== sbc_spi_command_frame.sv ====
`timescale 1ns/1ps
module sbc_spi_command_frame #(
   parameter logic CD_VERSION      = 1'b0,
   parameter int   CS_STUCK_CYCLES = sbc_spi_pkg::CS_STUCK_CYC
) (
   // System clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   // Serial link
   input  wire logic                                 sclk,
   input  wire logic                                 chip_select_n,
   input  wire logic                                 mosi,
   output logic                                      miso,
   output logic                                      miso_oe,
   // Status and flags from the rest of the device
   input  wire logic [7:0]                           fixed_status,
   input  wire logic [7:0]                           ext_status,
   input  wire logic [sbc_spi_pkg::NREG-1:0][7:0]    flag_bytes,
   // Register contents steering the device
   output logic [sbc_spi_pkg::NREG-1:0][7:0]         reg_bytes,
   // Executed write
   output logic                                      wr_stb,
   output logic [sbc_spi_pkg::ADDR_W-1:0]            wr_addr,
   output logic [7:0]                                wr_data,
   output logic                                      wr_parity,
   // Flag read, lets flag owners clear on read
   output logic                                      flag_rd_stb,
   output logic [sbc_spi_pkg::ADDR_W-1:0]            flag_rd_addr,
   // Link status
   output logic                                      csb_low_flag,
   output logic                                      write_deferred,
   output logic                                      frame_error
);

   // ----------------------------------------------------------------
   // Timer limits in clk cycles
   // ----------------------------------------------------------------
   // Lead limits are rounded inwards, so a lead accepted here also lies
   // inside the window in real time; a few ns of window are given up.
   localparam int STUCK_W = $clog2(CS_STUCK_CYCLES + 1);
   localparam logic [STUCK_W-1:0] STUCK_LAST = STUCK_W'(CS_STUCK_CYCLES - 1);
   localparam logic [STUCK_W-1:0] STUCK_ONE  = STUCK_W'(1);
   localparam logic [sbc_spi_pkg::LEAD_W-1:0] LEAD_ONE = sbc_spi_pkg::LEAD_W'(1);
   localparam logic [sbc_spi_pkg::LEAD_W-1:0] LEAD_SAT = '1;
   localparam logic [sbc_spi_pkg::LEAD_W-1:0] LEAD_MIN =
      CD_VERSION ? sbc_spi_pkg::LEAD_W'(sbc_spi_pkg::LEAD_MIN_CD_CYC)
                 : sbc_spi_pkg::LEAD_W'(sbc_spi_pkg::LEAD_MIN_CYC);
   localparam logic [sbc_spi_pkg::LEAD_W-1:0] LEAD_MAX = sbc_spi_pkg::LEAD_W'(sbc_spi_pkg::LEAD_MAX_CYC);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      // Frame phase and select history.
      sbc_spi_pkg::phase_e                        phase;
      logic                                       cs_low_d;
      logic                                       cs_low_d2;

      // Lead and stuck-low timers.
      logic [sbc_spi_pkg::LEAD_W-1:0]             lead_cnt;
      logic                                       lead_ok;
      logic [STUCK_W-1:0]                         low_cnt;
      logic                                       csb_flag;

      // Register file and the write held back for the next frame.
      logic [sbc_spi_pkg::NREG-1:0][7:0]          regs;
      logic                                       pend_valid;
      logic [sbc_spi_pkg::ADDR_W-1:0]             pend_addr;
      logic [7:0]                                 pend_data;
      logic                                       pend_parity;

      // Registered results toward the rest of the device.
      logic                                       wr_stb;
      logic [sbc_spi_pkg::ADDR_W-1:0]             wr_addr;
      logic [7:0]                                 wr_data;
      logic                                       wr_parity;
      logic                                       flag_rd_stb;
      logic [sbc_spi_pkg::ADDR_W-1:0]             flag_rd_addr;
      logic                                       write_deferred;
      logic                                       frame_error;

      // Reply frozen for the link while a frame runs.
      logic [7:0]                                 snap_fixed;
      logic [7:0]                                 snap_ext;
      logic [sbc_spi_pkg::NREG-1:0][7:0]          snap_regs;
      logic [sbc_spi_pkg::NREG-1:0][7:0]          snap_flags;
   } ctrl_s;

   ctrl_s                                  st;
   ctrl_s                                  next_st;

   logic                                   link_in_frame;
   logic [sbc_spi_pkg::FRAME_BITS-1:0]     link_word;
   logic [sbc_spi_pkg::CNT_W-1:0]          link_count;
   logic [1:0]                             synced;
   logic                                   cs_low;
   logic                                   started;
   logic [1:0]                             cmd;
   logic [sbc_spi_pkg::ADDR_W-1:0]         addr;
   logic [7:0]                             data;
   logic                                   parity;
   logic                                   frame_ok;
   logic                                   lead_fits;
   logic                                   stuck_set;
   logic                                   stuck_clear;
   logic                                   write_ok;

   // ----------------------------------------------------------------
   // Link side
   // ----------------------------------------------------------------
   spi_link u_link (
      .sclk          (sclk),
      .rst           (rst),
      .chip_select_n (chip_select_n),
      .mosi          (mosi),
      .miso          (miso),
      .miso_oe       (miso_oe),
      .fixed_status  (st.snap_fixed),
      .ext_status    (st.snap_ext),
      .reg_bytes     (st.snap_regs),
      .flag_bytes    (st.snap_flags),
      .in_frame      (link_in_frame),
      .frame_word    (link_word),
      .bit_count     (link_count)
   );

   // Chip select and the first-clock marker cross with the same latency,
   // so the cycles between them measure the lead time.
   sync_ff #(
      .WIDTH   (2),
      .RST_VAL (2'h2)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({chip_select_n, link_in_frame}),
      .q   (synced)
   );

   assign cs_low  = ~synced[1];
   assign started = synced[0];

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   // The link word and count are only read after select release, when the
   // link clock has stopped and both are stable.
   assign cmd       = link_word[sbc_spi_pkg::CMD_HI:sbc_spi_pkg::CMD_LO];
   assign addr      = link_word[sbc_spi_pkg::ADDR_MSB:sbc_spi_pkg::ADDR_LSB];
   assign data      = link_word[sbc_spi_pkg::DATA_MSB:sbc_spi_pkg::DATA_LSB];
   // Parity is passed on untested; whoever owns the parity setting judges it.
   assign parity    = link_word[sbc_spi_pkg::PN_BIT];
   // A frame without exactly sixteen clocks is dropped whole, never half applied.
   assign frame_ok  = (link_count == sbc_spi_pkg::CNT_FULL);
   // Both bounds count synchronised edges, which lag the pins by the same
   // two stages, so the count is the pin lead to within one cycle.
   assign lead_fits = (st.lead_cnt >= LEAD_MIN) && (st.lead_cnt <= LEAD_MAX);
   assign stuck_set = cs_low && (st.low_cnt == STUCK_LAST);

   // With the stuck flag up, a write is trusted only if its lead fell inside
   // the window; otherwise it waits for the next frame to land it.
   assign write_ok  = !st.csb_flag || st.lead_ok;

   always_comb begin
      next_st                = st;
      stuck_clear            = 1'b0;
      next_st.cs_low_d       = cs_low;
      next_st.cs_low_d2      = st.cs_low_d;
      next_st.wr_stb         = 1'b0;
      next_st.flag_rd_stb    = 1'b0;
      next_st.write_deferred = 1'b0;
      next_st.frame_error    = 1'b0;

      // ----------------------------------------------------------------
      // Stuck-low timer
      // ----------------------------------------------------------------
      // Stuck-low timer runs whenever select is low, whatever the phase.
      if (!cs_low) begin
         next_st.low_cnt = '0;
      end else if (st.low_cnt != STUCK_LAST) begin
         next_st.low_cnt = st.low_cnt + STUCK_ONE;
      end

      // ----------------------------------------------------------------
      // Frame sequencing
      // ----------------------------------------------------------------
      // The lead count runs from select seen low to the first clock seen.
      case (st.phase)
         sbc_spi_pkg::PH_IDLE: begin
            if (cs_low) begin
               next_st.phase    = sbc_spi_pkg::PH_LEAD;
               next_st.lead_cnt = '0;
               // A deferred write lands as soon as the next frame arrives.
               // It lands before that frame is decoded, so a second deferred
               // write can never overwrite one still held.
               if (st.pend_valid) begin
                  next_st.pend_valid         = 1'b0;
                  next_st.regs[st.pend_addr] = st.pend_data;
                  next_st.wr_stb             = 1'b1;
                  next_st.wr_addr            = st.pend_addr;
                  next_st.wr_data            = st.pend_data;
                  next_st.wr_parity          = st.pend_parity;
               end
            end
         end
         sbc_spi_pkg::PH_LEAD: begin
            // Released before any clock: nothing was shifted, so nothing acts.
            if (!cs_low) begin
               next_st.phase       = sbc_spi_pkg::PH_IDLE;
               next_st.frame_error = 1'b1;
            end else if (started) begin
               next_st.phase   = sbc_spi_pkg::PH_SHIFT;
               next_st.lead_ok = lead_fits;
            end else if (st.lead_cnt != LEAD_SAT) begin
               next_st.lead_cnt = st.lead_cnt + LEAD_ONE;
            end
         end
         sbc_spi_pkg::PH_SHIFT: begin
            if (!cs_low) begin
               next_st.phase = sbc_spi_pkg::PH_IDLE;
               if (!frame_ok) begin
                  next_st.frame_error = 1'b1;
               end else begin
                  case (cmd)
                     sbc_spi_pkg::CMD_WRITE: begin
                        // Only writes can be held back; reads never are.
                        if (write_ok) begin
                           next_st.regs[addr] = data;
                           next_st.wr_stb     = 1'b1;
                           next_st.wr_addr    = addr;
                           next_st.wr_data    = data;
                           next_st.wr_parity  = parity;
                        end else begin
                           next_st.pend_valid     = 1'b1;
                           next_st.pend_addr      = addr;
                           next_st.pend_data      = data;
                           next_st.pend_parity    = parity;
                           next_st.write_deferred = 1'b1;
                        end
                     end
                     sbc_spi_pkg::CMD_FLAGS: begin
                        // Other flag bytes are cleared by their owners on this strobe.
                        next_st.flag_rd_stb  = 1'b1;
                        next_st.flag_rd_addr = addr;
                        stuck_clear = (addr == sbc_spi_pkg::CSB_FLAG_ADDR);
                     end
                     sbc_spi_pkg::CMD_READ: begin
                        // Content was already shifted out; nothing changes.
                        next_st.lead_ok = st.lead_ok;
                     end
                     default: begin
                        next_st.lead_ok = st.lead_ok;
                     end
                  endcase
               end
            end
         end
         default: begin
            next_st.phase = sbc_spi_pkg::PH_IDLE;
         end
      endcase

      // ----------------------------------------------------------------
      // Stuck flag
      // ----------------------------------------------------------------
      // A new stuck event beats a clearing read in the same cycle.
      next_st.csb_flag = stuck_set | (st.csb_flag & ~stuck_clear);

      // ----------------------------------------------------------------
      // Reply snapshot
      // ----------------------------------------------------------------
      // Frozen from two cycles after select is seen low until it rises, so
      // the link reads a stable word; this leans on the master's lead time.
      if (!st.cs_low_d2) begin
         next_st.snap_fixed = fixed_status;
         next_st.snap_ext   = ext_status;
         next_st.snap_regs  = st.regs;
         next_st.snap_flags = flag_bytes;
         // The stuck flag has no owner outside, so it is merged into its
         // flag byte here for the flag read to show it.
         next_st.snap_flags[sbc_spi_pkg::CSB_FLAG_ADDR][sbc_spi_pkg::CSB_FLAG_BIT] =
            flag_bytes[sbc_spi_pkg::CSB_FLAG_ADDR][sbc_spi_pkg::CSB_FLAG_BIT] | st.csb_flag;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // The register file and its reply copy start at the named default, so a
   // read straight after reset already returns it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st            <= '0;
         st.phase      <= sbc_spi_pkg::PH_IDLE;
         st.regs       <= {sbc_spi_pkg::NREG{sbc_spi_pkg::REG_RESET}};
         st.snap_regs  <= {sbc_spi_pkg::NREG{sbc_spi_pkg::REG_RESET}};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output but miso and miso_oe comes straight from a flop, so a consumer on clk sees no glitch.
   assign reg_bytes      = st.regs;
   assign wr_stb         = st.wr_stb;
   assign wr_addr        = st.wr_addr;
   assign wr_data        = st.wr_data;
   assign wr_parity      = st.wr_parity;
   assign flag_rd_stb    = st.flag_rd_stb;
   assign flag_rd_addr   = st.flag_rd_addr;
   assign csb_low_flag   = st.csb_flag;
   assign write_deferred = st.write_deferred;
   assign frame_error    = st.frame_error;

endmodule : sbc_spi_command_frame

// ==== sbc_spi_pkg.sv ====
package sbc_spi_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int CNT_W      = 5;
   localparam int ADDR_W     = 5;
   localparam int NREG       = 32;
   localparam int LEAD_W     = 10;

   localparam int CMD_HI     = 15;
   localparam int CMD_LO     = 14;
   localparam int ADDR_MSB   = 13;
   localparam int ADDR_LSB   = 9;
   localparam int PN_BIT     = 8;
   localparam int DATA_MSB   = 7;
   localparam int DATA_LSB   = 0;
   localparam int STAT_LSB   = 8;

   localparam logic [1:0] CMD_READ  = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_RSVD  = 2'h2;
   localparam logic [1:0] CMD_FLAGS = 2'h3;

   localparam logic [CNT_W-1:0] CNT_ONE      = 5'h01;
   localparam logic [CNT_W-1:0] CNT_HDR_LAST = 5'h07;
   localparam logic [CNT_W-1:0] CNT_FULL     = 5'h10;
   localparam logic [CNT_W-1:0] CNT_MAX      = 5'h1f;

   localparam logic [ADDR_W-1:0] CSB_FLAG_ADDR = 5'h11;
   localparam int                CSB_FLAG_BIT  = 4;
   localparam logic [7:0]        REG_RESET     = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam real CLK_PERIOD_NS   = 8.0;
   localparam real LEAD_MIN_NS     = 550.0;
   localparam real LEAD_MIN_CD_NS  = 30.0;
   localparam real LEAD_MAX_US     = 2.5;
   localparam real CS_STUCK_MS     = 2.0;

   localparam int LEAD_MIN_CYC    = int'($ceil(LEAD_MIN_NS / CLK_PERIOD_NS));
   localparam int LEAD_MIN_CD_CYC = int'($ceil(LEAD_MIN_CD_NS / CLK_PERIOD_NS));
   localparam int LEAD_MAX_CYC    = int'($floor(LEAD_MAX_US * 1000.0 / CLK_PERIOD_NS));
   localparam int CS_STUCK_CYC    = int'($floor(CS_STUCK_MS * 1000000.0 / CLK_PERIOD_NS));

   typedef enum logic [1:0] {PH_IDLE, PH_LEAD, PH_SHIFT} phase_e;

endpackage : sbc_spi_pkg

// ==== sync_ff.sv ====
`timescale 1ns/1ps
module sync_ff #(
   parameter int                 WIDTH   = 1,
   parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s st;
   sync_s next_st;

   // Only the second stage is visible outside.
   always_comb begin
      next_st.meta   = d;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= {RST_VAL, RST_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign q = st.stable;

endmodule : sync_ff

// ==== spi_link.sv ====
`timescale 1ns/1ps
module spi_link (
   // Link clock and reset
   input  wire logic                                   sclk,
   input  wire logic                                   rst,
   // Serial pins
   input  wire logic                                   chip_select_n,
   input  wire logic                                   mosi,
   output logic                                        miso,
   output logic                                        miso_oe,
   // Reply snapshot, frozen by the system side during a frame
   input  wire logic [7:0]                             fixed_status,
   input  wire logic [7:0]                             ext_status,
   input  wire logic [sbc_spi_pkg::NREG-1:0][7:0]      reg_bytes,
   input  wire logic [sbc_spi_pkg::NREG-1:0][7:0]      flag_bytes,
   // Frame result
   output logic                                        in_frame,
   output logic [sbc_spi_pkg::FRAME_BITS-1:0]          frame_word,
   output logic [sbc_spi_pkg::CNT_W-1:0]               bit_count
);

   typedef struct packed {
      logic [sbc_spi_pkg::CNT_W-1:0]      count;
      logic [sbc_spi_pkg::FRAME_BITS-1:0] shift;
      logic [7:0]                         header;
   } link_s;

   link_s                             st;
   link_s                             next_st;
   logic                              frame_clr;
   logic [sbc_spi_pkg::CNT_W-1:0]     cur;
   logic [1:0]                        hdr_cmd;
   logic [sbc_spi_pkg::ADDR_W-1:0]    hdr_addr;
   logic [7:0]                        low_byte;
   logic [sbc_spi_pkg::FRAME_BITS-1:0] reply;

   // ----------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------
   // The serial clock stands still between frames, so the frame marker
   // is cleared by chip select itself rather than by a clock edge.
   assign frame_clr = rst | chip_select_n;

   always_ff @(posedge sclk or posedge frame_clr) begin
      if (frame_clr) begin
         in_frame <= 1'b0;
      end else begin
         in_frame <= 1'b1;
      end
   end

   always_comb begin
      next_st = st;
      if (!in_frame) begin
         next_st.count = sbc_spi_pkg::CNT_ONE;
         next_st.shift = {15'h0000, mosi};
      end else begin
         if (st.count != sbc_spi_pkg::CNT_MAX) begin
            next_st.count = st.count + sbc_spi_pkg::CNT_ONE;
         end
         next_st.shift = {st.shift[sbc_spi_pkg::FRAME_BITS-2:0], mosi};
         if (st.count == sbc_spi_pkg::CNT_HDR_LAST) begin
            next_st.header = {st.shift[6:0], mosi};
         end
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Reply
   // ----------------------------------------------------------------
   assign hdr_cmd  = st.header[sbc_spi_pkg::CMD_HI-sbc_spi_pkg::STAT_LSB:sbc_spi_pkg::CMD_LO-sbc_spi_pkg::STAT_LSB];
   assign hdr_addr = st.header[sbc_spi_pkg::ADDR_MSB-sbc_spi_pkg::STAT_LSB:sbc_spi_pkg::ADDR_LSB-sbc_spi_pkg::STAT_LSB];
   assign cur      = in_frame ? st.count : '0;

   always_comb begin
      case (hdr_cmd)
         sbc_spi_pkg::CMD_WRITE: low_byte = ext_status;
         sbc_spi_pkg::CMD_READ:  low_byte = reg_bytes[hdr_addr];
         sbc_spi_pkg::CMD_FLAGS: low_byte = flag_bytes[hdr_addr];
         default:                low_byte = 8'h00;
      endcase
   end

   // MISO carries only device state, but the MOSI header's command and address pick which byte goes in the low half.
   assign reply    = {fixed_status, low_byte};
   assign miso     = (cur < sbc_spi_pkg::CNT_FULL) ? reply[~cur[3:0]] : 1'b0;
   assign miso_oe  = ~chip_select_n;

   assign frame_word = st.shift;
   assign bit_count  = st.count;

endmodule : spi_link

// ==== sbc_spi_checker.sv ====
`timescale 1ns/1ps
module sbc_spi_checker #(parameter int CS_STUCK_CYCLES = 64) (
   // Watched ports
   input wire logic clk, rst, chip_select_n, miso_oe, wr_stb, flag_rd_stb, csb_low_flag, write_deferred,
   input wire logic [sbc_spi_pkg::ADDR_W-1:0] wr_addr, flag_rd_addr,
   input wire logic [7:0] wr_data,
   input wire logic [sbc_spi_pkg::NREG-1:0][7:0] reg_bytes
);
   // A few cycles of margin cover the select synchroniser.
   int low_cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) low_cnt <= 0;
      else low_cnt <= chip_select_n ? 0 : low_cnt + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_flag_read;
      flag_rd_stb && flag_rd_addr == sbc_spi_pkg::CSB_FLAG_ADDR && chip_select_n;
   endsequence
   a_oe_follows_select: assert property (miso_oe == !chip_select_n) else $error("oe wrong");
   a_write_lands: assert property (wr_stb |-> reg_bytes[wr_addr] == wr_data) else $error("reg wrong");
   a_write_pulse: assert property (wr_stb |=> !wr_stb) else $error("pulse long");
   a_write_held: assert property (!wr_stb |-> $stable(wr_addr) && $stable(wr_data)) else $error("moved");
   a_flag_read_late: assert property (flag_rd_stb |-> $past(chip_select_n, 2)) else $error("early");
   a_stuck_sets: assert property (low_cnt > CS_STUCK_CYCLES + 4 |-> csb_low_flag) else $error("no flag");
   a_flag_clears: assert property (s_flag_read |-> !csb_low_flag) else $error("flag kept");
   a_defer_flagged: assert property (write_deferred |-> csb_low_flag) else $error("bad defer");
endmodule : sbc_spi_checker
bind sbc_spi_command_frame sbc_spi_checker #(.CS_STUCK_CYCLES(CS_STUCK_CYCLES)) u_chk (.*);

// ==== spi_master.sv ====
`timescale 1ns/1ps
module spi_master (
   // Serial pins
   output logic     sclk,
   output logic     chip_select_n,
   output logic     mosi,
   input wire logic miso
);
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, input int lead, input int nb, output logic [15:0] rx);
      chip_select_n = 1'b0;
      #(lead);
      for (int i = 15; i > 15 - nb; i--) begin
         mosi = tx[i];
         #15 rx[i] = miso;
         sclk = 1'b1;
         #15 sclk = 1'b0;
      end
      if (lead < 5600) #(5600 - lead - nb * 30);
      chip_select_n = 1'b1;
      // A released line must not keep looking valid.
      mosi = ~mosi;
      #200;
   endtask : xfer
endmodule : spi_master

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst = 1'b1, sclk, chip_select_n, mosi, miso, miso_oe, wr_stb, wr_parity;
   logic flag_rd_stb, csb_low_flag, write_deferred, frame_error;
   logic [7:0] fixed_status = 8'h00, ext_status = 8'h00, wr_data, d, mdl [32] = '{default: 8'h00};
   logic [sbc_spi_pkg::NREG-1:0][7:0] flag_bytes = '0, reg_bytes;
   logic [4:0] wr_addr, flag_rd_addr, a;
   logic [15:0] rx;
   int failures = 0, n_compared = 0, n_wr = 0, n_def = 0, n_err = 0;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      n_wr += int'(wr_stb === 1'b1);
      n_def += int'(write_deferred === 1'b1);
      n_err += int'(frame_error === 1'b1);
   end
   sbc_spi_command_frame #(.CS_STUCK_CYCLES(1000)) u_dut (.*);
   spi_master u_m (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic frm(input logic [15:0] w, input int lead = 1000, input int nb = 16);
      u_m.xfer(w, lead, nb, rx);
      repeat (12) @(negedge clk);
   endtask : frm
   task automatic test_done;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   initial begin
      #500000;
      failures++;
      test_done();
   end
   initial begin
      void'($urandom(32'hd9dcee4f));
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      for (int k = 1; k < 7; k++) begin
         a = 5'($urandom_range(0, 16));
         d = 8'($urandom);
         {fixed_status, ext_status} = 16'($urandom);
         flag_bytes[a] = 8'($urandom);
         frm({2'h1, a, d[0], d});
         chk(rx, {fixed_status, ext_status});
         mdl[a] = d;
         chk(16'(n_wr), 16'(k));
         chk({2'h0, wr_parity, wr_addr, wr_data}, {2'h0, d[0], a, d});
         frm({2'h0, a, 1'b1, 8'h00});
         chk(rx, {fixed_status, mdl[a]});
         frm({2'h3, a, 1'b1, 8'h00});
         chk(rx, {fixed_status, flag_bytes[a]});
         chk({11'h000, flag_rd_addr}, {11'h000, a});
      end
      $display("register traffic done");
      frm({2'h2, a, 1'b1, 8'h5a});
      chk(rx, {fixed_status, 8'h00});
      frm({2'h1, a, 1'b0, ~mdl[a]}, 1000, 15);
      chk({8'(n_err), reg_bytes[a]}, {8'h01, mdl[a]});
      chk(16'(n_wr), 16'h0006);
      $display("refusals done");
      frm(16'h0000, 9000, 0);
      chk(16'(csb_low_flag), 16'h0001);
      frm(16'h60c0, 3000);
      chk({8'(n_def), reg_bytes[16]}, {8'h01, mdl[16]});
      frm(16'h2580);
      chk(16'(reg_bytes[16]), 16'h00c0);
      chk(rx, {fixed_status, sbc_spi_pkg::REG_RESET});
      frm({2'h1, 5'h10, 1'b0, 8'h3c});
      chk({8'(n_def), reg_bytes[16]}, {8'h01, 8'h3c});
      frm(16'he300);
      chk({14'h0, rx[4], csb_low_flag}, 16'h0002);
      frm({2'h1, 5'h10, 1'b1, 8'ha5}, 3000);
      chk({8'(n_def), reg_bytes[16]}, {8'h01, 8'ha5});
      frm(16'h2580);
      $display("stuck select done");
      test_done();
   end
endmodule : testbench
